// ### rtl/spcs_pkg.sv
package spcs_pkg;

  localparam logic [7:0] SPCS_CTRL_ADDR = 8'hf8;
  localparam int SPCS_BIT_DONE = 7;
  localparam int SPCS_BIT_WRITE_COLLISION_FLAG = 6;
  localparam int SPCS_BIT_MODE_FAULT_FLAG = 5;
  localparam int SPCS_BIT_OVRN = 4;
  localparam int SPCS_BIT_MODE_HI = 3;
  localparam int SPCS_BIT_MODE_LO = 2;
  localparam int SPCS_BIT_TXE = 1;
  localparam int SPCS_BIT_EN = 0;
  localparam logic [7:0] SPCS_CTRL_RESET = 8'h06;
  localparam logic [1:0] SPCS_MODE_3WIRE = 2'h0;
  localparam logic [1:0] SPCS_MODE_4SLAVE = 2'h1;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic [1:0] select_mode_field;
    logic tx_buffer_empty;
    logic port_enable;
  } spcs_ctrl_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spcs_sfr_req_t;

endpackage

// ### rtl/spcs_sync.sv
module spcs_sync
  import spcs_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### rtl/spcs_ctrl.sv
// Notes on behaviour
// - Set done flag at each transfer end and interrupt; only software clears it.
// - Data write during a transfer sets collision flag and interrupts; software clears.
// - Select low, master enabled and mode 01 set mode fault and interrupt.
// - Mode 00 is three-wire; select pin unused.
// - Mode 01 is four-wire slave or multi-master, select is input; reset default.
// - Mode 1x drives select out at the level of the low mode bit.
// - A transmit buffer write that does not collide clears the buffer-empty status, unless a load in the same cycle sets it.
// - Buffer moving into the shifter sets the buffer-empty status.
module spcs_ctrl
  import spcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire spcs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic data_wr,
  input wire logic rx_read,
  input wire logic master_enable,
  input wire logic shift_busy,
  input wire logic shift_done,
  input wire logic shift_load,
  input wire logic slave_select_pin_in,
  output logic slave_select_pin_out,
  output logic slave_select_pin_oe,
  output logic slave_select_active,
  output logic port_active,
  output logic port_irq
);

  localparam int FLAG_LO = SPCS_BIT_OVRN;
  localparam int FLAG_HI = SPCS_BIT_DONE;
  localparam int FLAG_COUNT = FLAG_HI - FLAG_LO + 1;
  localparam spcs_ctrl_t CTRL_RESET = spcs_ctrl_t'(SPCS_CTRL_RESET);

  // Fields that only software changes.
  logic port_enable_q;
  logic port_enable_d;
  logic [1:0] select_mode_q;
  logic [1:0] select_mode_d;

  // Event flags, indexed from the receive overrun flag upwards.
  logic [FLAG_COUNT-1:0] flag_q;
  logic [FLAG_COUNT-1:0] flag_d;
  logic [FLAG_COUNT-1:0] flag_set;
  logic [FLAG_COUNT-1:0] flag_keep;

  logic tx_empty_q;
  logic tx_empty_d;
  logic rx_full_q;
  logic rx_full_d;

  logic ss_sync;
  logic mode_three_wire;
  logic mode_slave_in;
  logic mode_drive_out;
  logic ctrl_wr;
  spcs_ctrl_t wr_val;
  spcs_ctrl_t ctrl_view;
  logic done_ev;
  logic write_collision_flag_ev;
  logic fault_ev;
  logic ovrn_ev;
  logic fill_ev;
  logic load_ev;

  // The select pin is asynchronous to clk, so it is resynchronised first.
  spcs_sync #(
    .WIDTH(1)
  ) u_ss_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(slave_select_pin_in),
    .sync_out(ss_sync)
  );

  // Select mode decode; the upper mode bit alone picks the driven-select mode.
  always_comb begin
    mode_three_wire = 1'b0;
    mode_slave_in = 1'b0;
    mode_drive_out = 1'b0;
    case (select_mode_q)
      SPCS_MODE_3WIRE: begin
        mode_three_wire = 1'b1;
      end
      SPCS_MODE_4SLAVE: begin
        mode_slave_in = 1'b1;
      end
      default: begin
        mode_drive_out = 1'b1;
      end
    endcase
  end

  // Event decode; nothing but a buffer write counts while the port is off.
  always_comb begin
    ctrl_wr = sfr_req.wr && (sfr_req.addr == SPCS_CTRL_ADDR);
    wr_val = spcs_ctrl_t'(sfr_req.wdata);
    done_ev = port_enable_q && shift_done;
    write_collision_flag_ev = port_enable_q && data_wr && shift_busy;
    // The select level passes two synchroniser stages before a fault is flagged.
    fault_ev = port_enable_q && !ss_sync && master_enable
               && mode_slave_in;
    ovrn_ev = done_ev && !master_enable && rx_full_q && !rx_read;
    // A write that collides leaves the buffer-empty status as it was.
    fill_ev = data_wr && !write_collision_flag_ev;
    load_ev = port_enable_q && shift_load;
  end

  // Enable and select mode group.
  always_comb begin
    port_enable_d = port_enable_q;
    select_mode_d = select_mode_q;
    if (ctrl_wr) begin
      port_enable_d = wr_val.port_enable;
      select_mode_d = wr_val.select_mode_field;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_enable_q <= CTRL_RESET.port_enable;
      select_mode_q <= CTRL_RESET.select_mode_field;
    end else begin
      port_enable_q <= port_enable_d;
      select_mode_q <= select_mode_d;
    end
  end

  // Event flag group.
  always_comb begin
    flag_set = '0;
    flag_set[SPCS_BIT_DONE - FLAG_LO] = done_ev;
    flag_set[SPCS_BIT_WRITE_COLLISION_FLAG - FLAG_LO] = write_collision_flag_ev;
    flag_set[SPCS_BIT_MODE_FAULT_FLAG - FLAG_LO] = fault_ev;
    flag_set[SPCS_BIT_OVRN - FLAG_LO] = ovrn_ev;
    flag_keep = '1;
    if (ctrl_wr) begin
      // A written 1 keeps a flag as it is; only a written 0 clears it.
      flag_keep = sfr_req.wdata[FLAG_HI:FLAG_LO];
    end
    // Hardware setting wins over a clear that lands in the same cycle.
    flag_d = (flag_q & flag_keep) | flag_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= SPCS_CTRL_RESET[FLAG_HI:FLAG_LO];
    end else begin
      flag_q <= flag_d;
    end
  end

  // Transmit buffer empty group.
  always_comb begin
    tx_empty_d = tx_empty_q;
    if (fill_ev) begin
      tx_empty_d = 1'b0;
    end
    if (load_ev) begin
      tx_empty_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_empty_q <= CTRL_RESET.tx_buffer_empty;
    end else begin
      tx_empty_q <= tx_empty_d;
    end
  end

  // Receive buffer occupancy, tracked only to detect an overrun.
  always_comb begin
    rx_full_d = rx_full_q;
    if (rx_read) begin
      rx_full_d = 1'b0;
    end
    if (done_ev) begin
      rx_full_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_full_q <= 1'b0;
    end else begin
      rx_full_q <= rx_full_d;
    end
  end

  // Register read view.
  always_comb begin
    ctrl_view.transfer_done_flag = flag_q[SPCS_BIT_DONE - FLAG_LO];
    ctrl_view.write_collision_flag = flag_q[SPCS_BIT_WRITE_COLLISION_FLAG - FLAG_LO];
    ctrl_view.mode_fault_flag = flag_q[SPCS_BIT_MODE_FAULT_FLAG - FLAG_LO];
    ctrl_view.receive_overrun_flag = flag_q[SPCS_BIT_OVRN - FLAG_LO];
    ctrl_view.select_mode_field = select_mode_q;
    ctrl_view.tx_buffer_empty = tx_empty_q;
    ctrl_view.port_enable = port_enable_q;
  end

  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_req.addr == SPCS_CTRL_ADDR) begin
      sfr_rdata = ctrl_view;
    end
  end

  // Pin side and engine side outputs.
  always_comb begin
    port_active = port_enable_q;
    port_irq = |flag_q;
    slave_select_pin_oe = port_enable_q && mode_drive_out;
    slave_select_pin_out = select_mode_q[0];
    slave_select_active = port_enable_q
                          && (mode_three_wire || mode_drive_out || !ss_sync);
  end

endmodule

// ### bench/spcs_ctrl_assertions.sv
module spcs_ctrl_chk
  import spcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire spcs_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic data_wr,
  input wire logic master_enable,
  input wire logic shift_busy,
  input wire logic shift_done,
  input wire logic shift_load,
  input wire logic slave_select_pin_in,
  input wire logic slave_select_pin_out,
  input wire logic slave_select_pin_oe,
  input wire logic port_active,
  input wire logic port_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd = sfr_req.addr == SPCS_CTRL_ADDR;
  sequence fault_s;
    rd && sfr_rdata[3:2] == SPCS_MODE_4SLAVE && port_active && master_enable
      && !slave_select_pin_in;
  endsequence
  done_set_a: assert property (
    port_active && shift_done |=> port_irq) else $error("Done lost.");
  done_hold_a: assert property (
    rd && sfr_rdata[7] && !sfr_req.wr |=> !rd || sfr_rdata[7]) else $error("Done cleared.");
  write_collision_flag_set_a: assert property (
    port_active && data_wr && shift_busy |=> port_irq) else $error("Collision lost.");
  fault_set_a: assert property (
    fault_s [*3] |=> port_irq) else $error("Mode fault lost.");
  sel_out_a: assert property (
    rd && port_active && sfr_rdata[3] |-> slave_select_pin_oe
      && slave_select_pin_out == sfr_rdata[2]) else $error("Select out wrong.");
  sel_off_a: assert property (
    rd && !sfr_rdata[3] |-> !slave_select_pin_oe) else $error("Select driven.");
  txe_clr_a: assert property (
    data_wr && !shift_busy && !shift_load |=> !rd || !sfr_rdata[1]) else $error("Empty kept.");
  txe_set_a: assert property (
    port_active && shift_load && !data_wr |=> !rd || sfr_rdata[1]) else $error("Empty lost.");
endmodule
bind spcs_ctrl spcs_ctrl_chk spcs_ctrl_chk_i (
  .clk(clk),
  .rst_b(rst_b),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .data_wr(data_wr),
  .master_enable(master_enable),
  .shift_busy(shift_busy),
  .shift_done(shift_done),
  .shift_load(shift_load),
  .slave_select_pin_in(slave_select_pin_in),
  .slave_select_pin_out(slave_select_pin_out),
  .slave_select_pin_oe(slave_select_pin_oe),
  .port_active(port_active),
  .port_irq(port_irq)
);

// ### bench/spcs_peer.sv
module spcs_peer (
  input wire logic go,
  output logic sel_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sck = 1'b0;
  initial sel_b = 1'b1;
  // The link clock runs only inside a frame.
  always @(posedge go) begin
    sel_b = 1'b0;
    repeat (16) #400 sck = ~sck;
    sel_b = 1'b1;
  end
endmodule

// ### bench/testbench.sv
module testbench;
  import spcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  spcs_sfr_req_t rq = '{1'b0, SPCS_CTRL_ADDR, 8'h00};
  logic dw = 1'b0, rr = 1'b0, me = 1'b0, bz = 1'b0, sd = 1'b0, sl = 1'b0, go = 1'b0;
  logic sel_b, so, oe, irq, act, pa;
  logic [7:0] q;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  wire pin = oe ? so : sel_b;
  // Outputs seen, high to low: enable, active, select drive, select level, irq, register.
  wire [12:0] obs = {pa, act, oe, so, irq, q};
  always #50 clk = ~clk;
  spcs_ctrl spcs_ctrl_i (.clk(clk), .rst_b(rst_b), .sfr_req(rq), .sfr_rdata(q), .data_wr(dw),
    .rx_read(rr), .master_enable(me), .shift_busy(bz), .shift_done(sd), .shift_load(sl),
    .slave_select_pin_in(pin), .slave_select_pin_out(so), .slave_select_pin_oe(oe),
    .slave_select_active(act), .port_active(pa), .port_irq(irq));
  spcs_peer spcs_peer_i (.go(go), .sel_b(sel_b));
  task automatic chk(logic [12:0] e);
    checks_done++;
    if (obs !== e) begin
      $display("Error %0t: got %h want %h", $time, obs, e);
      errors++;
    end
  endtask
  task automatic wr(logic [7:0] d);
    rq.wr = 1'b1;
    rq.wdata = d;
    @(negedge clk) rq.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk) s = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_reset;
    chk(13'h0206);
    rq.addr = 8'h00;
    @(negedge clk);
    chk(13'h0200);
    rq.addr = SPCS_CTRL_ADDR;
    pulse(sd);
    chk(13'h0206);
  endtask
  task automatic t_done;
    wr(8'h07);
    rr = 1'b1;
    sd = 1'b1;
    @(negedge clk);
    rr = 1'b0;
    sd = 1'b0;
    @(negedge clk);
    chk(13'h1387);
    pulse(sd);
    chk(13'h1397);
    wr(8'h07);
    chk(13'h1207);
  endtask
  task automatic t_write_collision_flag;
    bz = 1'b1;
    pulse(dw);
    bz = 1'b0;
    chk(13'h1347);
    wr(8'h07);
    pulse(dw);
    chk(13'h1205);
    pulse(sl);
    chk(13'h1207);
  endtask
  task automatic t_fault;
    me = 1'b1;
    go = 1'b1;
    repeat (4) @(negedge clk);
    chk(13'h1b27);
    go = 1'b0;
    me = 1'b0;
    repeat (70) @(negedge clk);
    wr(8'h07);
    chk(13'h1207);
  endtask
  task automatic t_mode;
    wr(8'h0d);
    chk(13'h1e0f);
    wr(8'h09);
    chk(13'h1c0b);
    wr(8'h01);
    chk(13'h1803);
  endtask
  task end_of_test;
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_done;
    t_write_collision_flag;
    t_fault;
    t_mode;
    end_of_test;
  end
endmodule
